//--- src/traverse_pkg.sv
package traverse_pkg;
    // interpolation cycle and minimum request-to-interrupt spacing
    localparam int unsigned IPO_PERIOD_NS  = 2000;
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned IPO_CYCLES     = IPO_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned MIN_INT_IPO    = 3;
    localparam int unsigned POS_W          = 32;
    localparam int unsigned DWELL_W        = 16;
    localparam int unsigned IPO_CNT_W      = 12;
    localparam logic [IPO_CNT_W-1:0] IPO_LAST = IPO_CNT_W'(IPO_CYCLES - 1);
    localparam logic [1:0] GAP_LAST        = 2'(MIN_INT_IPO);
    localparam logic [POS_W-1:0] STEP      = 32'h0000_0001;
    localparam logic [DWELL_W-1:0] DWELL_ZERO = 16'h0000;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b00_0001,
        ST_MOVE   = 6'b00_0010,
        ST_DWELL  = 6'b00_0100,
        ST_HALT   = 6'b00_1000,
        ST_JOG    = 6'b01_0000,
        ST_REF    = 6'b10_0000
    } axis_state_type;

    typedef enum logic [2:0] {
        HS_WAIT  = 3'b001,
        HS_GAP   = 3'b010,
        HS_RUN   = 3'b100
    } host_state_type;
endpackage

//--- src/traverse_if.sv
`timescale 1ns/1ps
`default_nettype none
interface traverse_if;
    logic                           start_task;
    logic                           stop_hold;
    logic                           reject_task;
    logic                           jog_req;
    logic                           ref_req;
    logic                           is_dwell;
    logic [traverse_pkg::DWELL_W-1:0] dwell_time;
    logic [traverse_pkg::POS_W-1:0]   target_pos;
    logic                           use_bus_target;
    logic [traverse_pkg::POS_W-1:0]   bus_target;
    logic                           enables_ok;
    logic                           ctrl_enabled;
    logic                           followup_active_status_bit;
    logic                           block_active;
    logic                           in_position;
    logic                           halted;
    logic                           ipo_tick;
    logic [traverse_pkg::POS_W-1:0]   actual_pos;

    modport device (
        input  start_task, stop_hold, reject_task, jog_req, ref_req, is_dwell, dwell_time,
               target_pos, use_bus_target, bus_target,
        output enables_ok, ctrl_enabled, followup_active_status_bit, block_active,
               in_position, halted, ipo_tick, actual_pos
    );
    modport host (
        output start_task, stop_hold, reject_task, jog_req, ref_req, is_dwell, dwell_time,
               target_pos, use_bus_target, bus_target,
        input  enables_ok, ctrl_enabled, followup_active_status_bit, block_active,
               in_position, halted, ipo_tick, actual_pos
    );
endinterface
`default_nettype wire

//--- src/traverse_device.sv
`timescale 1ns/1ps
`default_nettype none
module traverse_device (
    // clock and reset
    input  wire logic                            CLK_SYS,
    input  wire logic                            RSTN,
    // drive enables
    input  wire logic                            DRV_ENABLES,
    input  wire logic                            DRV_CTRL_ENABLED,
    // spindle positioning target setting
    input  wire logic [traverse_pkg::POS_W-1:0]  SPINDLE_TARGET_SETTING,
    // link
    traverse_if.device                           lnk
);
    traverse_pkg::axis_state_type      state, next_state;
    logic [traverse_pkg::IPO_CNT_W-1:0] ipo_cnt, next_ipo_cnt;
    logic [traverse_pkg::POS_W-1:0]    pos, next_pos;
    logic [traverse_pkg::POS_W-1:0]    goal, next_goal;
    logic [traverse_pkg::DWELL_W-1:0]  dwell, next_dwell;
    logic                              tick, next_tick;
    logic                              en_q, next_en_q;
    logic                              ce_q, next_ce_q;
    logic                              start_ok;
    logic                              followup, next_followup;
    logic                              active, next_active;
    logic                              inpos, next_inpos;
    logic                              held, next_held;

    // states in which the axis still owns a traversing block
    function automatic logic in_block(input traverse_pkg::axis_state_type s);
        return (s == traverse_pkg::ST_MOVE) || (s == traverse_pkg::ST_DWELL) || (s == traverse_pkg::ST_HALT);
    endfunction

    // jog and referencing both report follow-up to the host
    function automatic logic in_followup(input traverse_pkg::axis_state_type s);
        return (s == traverse_pkg::ST_JOG) || (s == traverse_pkg::ST_REF);
    endfunction

    // preconditions to accept a new block
    assign start_ok = en_q && ce_q && (state == traverse_pkg::ST_IDLE);

    always_comb begin
        next_state   = state;
        next_pos     = pos;
        next_goal    = goal;
        next_dwell   = dwell;
        // enables registered once, so a start needs them a cycle ahead
        next_en_q    = DRV_ENABLES;
        next_ce_q    = DRV_CTRL_ENABLED;
        next_tick    = (ipo_cnt == traverse_pkg::IPO_LAST);
        next_ipo_cnt = next_tick ? '0 : ipo_cnt + 1'b1;
        // motion advances once per interpolation cycle only, except the instant zeroing in ST_REF
        case (state)
            traverse_pkg::ST_IDLE: begin
                // a start outside idle or without enables is dropped silently
                if (lnk.start_task && start_ok) begin
                    if (lnk.is_dwell) begin
                        next_dwell = lnk.dwell_time;
                        next_state = traverse_pkg::ST_DWELL;
                    end else begin
                        // spindle target chosen by source select
                        next_goal  = lnk.use_bus_target ? lnk.bus_target
                                                        : SPINDLE_TARGET_SETTING;
                        if (!lnk.use_bus_target && lnk.target_pos != SPINDLE_TARGET_SETTING)
                            next_goal = lnk.target_pos;
                        next_state = traverse_pkg::ST_MOVE;
                    end
                end else if (lnk.jog_req && en_q && ce_q) begin
                    next_state = traverse_pkg::ST_JOG;
                end else if (lnk.ref_req && en_q && ce_q) begin
                    next_state = traverse_pkg::ST_REF;
                end
            end
            traverse_pkg::ST_MOVE: begin
                // reject wins over stop: the rest of the path is dropped, not parked
                if (lnk.reject_task) begin
                    next_goal  = pos;
                    next_state = traverse_pkg::ST_IDLE;
                end else if (lnk.stop_hold) begin
                    next_state = traverse_pkg::ST_HALT;
                end else if (pos == goal) begin
                    next_state = traverse_pkg::ST_IDLE;
                end else if (tick) begin
                    next_pos = (goal > pos) ? pos + traverse_pkg::STEP : pos - traverse_pkg::STEP;
                end
            end
            traverse_pkg::ST_DWELL: begin
                // reject clears the countdown so nothing is left to resume
                if (lnk.reject_task) begin
                    next_dwell = traverse_pkg::DWELL_ZERO;
                    next_state = traverse_pkg::ST_IDLE;
                end else if (lnk.stop_hold) begin
                    next_state = traverse_pkg::ST_HALT;
                end else if (dwell == traverse_pkg::DWELL_ZERO) begin
                    next_state = traverse_pkg::ST_IDLE;
                end else if (tick) begin
                    next_dwell = dwell - 1'b1;
                end
            end
            traverse_pkg::ST_HALT: begin
                // dwell and goal stay frozen while held
                // jog or referencing drops the block for good, as reject does
                if (lnk.reject_task) begin
                    next_goal  = pos;
                    next_dwell = traverse_pkg::DWELL_ZERO;
                    next_state = traverse_pkg::ST_IDLE;
                end else if (lnk.jog_req) begin
                    next_goal  = pos;
                    next_dwell = traverse_pkg::DWELL_ZERO;
                    next_state = traverse_pkg::ST_JOG;
                end else if (lnk.ref_req) begin
                    next_goal  = pos;
                    next_dwell = traverse_pkg::DWELL_ZERO;
                    next_state = traverse_pkg::ST_REF;
                end else if (!lnk.stop_hold) begin
                    next_state = (dwell != traverse_pkg::DWELL_ZERO) ? traverse_pkg::ST_DWELL
                                                                     : traverse_pkg::ST_MOVE;
                end
            end
            traverse_pkg::ST_JOG: begin
                // follow-up stays active until jog request dropped
                if (!lnk.jog_req) begin
                    next_goal  = pos;
                    next_state = traverse_pkg::ST_IDLE;
                end else if (tick) begin
                    next_pos = pos + traverse_pkg::STEP;
                end
            end
            traverse_pkg::ST_REF: begin
                // referencing modelled as an instant zeroing of position
                next_pos   = '0;
                next_goal  = '0;
                next_state = traverse_pkg::ST_IDLE;
            end
            default: begin
                // a broken one-hot code falls back to idle
                next_state = traverse_pkg::ST_IDLE;
            end
        endcase
    end

    // axis state, reset to an idle axis at position zero
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state   <= traverse_pkg::ST_IDLE;
            ipo_cnt <= '0;
            pos     <= '0;
            goal    <= '0;
            dwell   <= traverse_pkg::DWELL_ZERO;
            tick    <= 1'b0;
            en_q    <= 1'b0;
            ce_q    <= 1'b0;
        end else begin
            state   <= next_state;
            ipo_cnt <= next_ipo_cnt;
            pos     <= next_pos;
            goal    <= next_goal;
            dwell   <= next_dwell;
            tick    <= next_tick;
            en_q    <= next_en_q;
            ce_q    <= next_ce_q;
        end
    end

    // status taken from next values so each flag lines up with the state
    always_comb begin
        next_followup = in_followup(next_state);
        next_active   = in_block(next_state);
        next_inpos    = (next_state == traverse_pkg::ST_IDLE) && (next_pos == next_goal);
        next_held     = (next_state == traverse_pkg::ST_HALT);
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            followup <= 1'b0;
            active   <= 1'b0;
            // nothing pending after reset, so the axis counts as in position
            inpos    <= 1'b1;
            held     <= 1'b0;
        end else begin
            followup <= next_followup;
            active   <= next_active;
            inpos    <= next_inpos;
            held     <= next_held;
        end
    end

    // link outputs, each straight from a register
    assign lnk.enables_ok                 = en_q;
    assign lnk.ctrl_enabled               = ce_q;
    assign lnk.followup_active_status_bit = followup;
    assign lnk.block_active               = active;
    assign lnk.in_position                = inpos;
    assign lnk.halted                     = held;
    assign lnk.ipo_tick                   = tick;
    assign lnk.actual_pos                 = pos;
endmodule
`default_nettype wire

//--- src/traverse_host.sv
`timescale 1ns/1ps
`default_nettype none
module traverse_host (
    // clock and reset
    input  wire logic                              CLK_SYS,
    input  wire logic                              RSTN,
    // user requests
    input  wire logic                              GO,
    input  wire logic                              GO_DWELL,
    input  wire logic [traverse_pkg::DWELL_W-1:0]  DWELL_TIME,
    input  wire logic [traverse_pkg::POS_W-1:0]    TARGET,
    input  wire logic                              BUS_TARGET_SEL,
    input  wire logic                              HOLD,
    input  wire logic                              ABORT,
    input  wire logic                              JOG,
    input  wire logic                              HOME,
    // user status
    output logic                                   BUSY,
    output logic                                   DONE,
    // link
    traverse_if.host                               lnk
);
    traverse_pkg::host_state_type hs, next_hs;
    logic [1:0] gap, next_gap;
    logic start_q, next_start_q;
    logic hold_q, next_hold_q;
    logic rej_q, next_rej_q;
    logic busy_q, next_busy_q;
    logic done_q, next_done_q;
    logic can_start;

    assign can_start = lnk.enables_ok && lnk.ctrl_enabled
                       && !lnk.followup_active_status_bit
                       && lnk.in_position && !lnk.block_active;

    always_comb begin
        next_hs      = hs;
        next_gap     = gap;
        next_start_q = 1'b0;
        next_hold_q  = 1'b0;
        next_rej_q   = 1'b0;
        next_busy_q  = busy_q;
        next_done_q  = 1'b0;
        case (hs)
            traverse_pkg::HS_WAIT: begin
                if ((GO || GO_DWELL) && can_start && !JOG && !HOME) begin
                    next_start_q = 1'b1;
                    next_gap     = '0;
                    next_busy_q  = 1'b1;
                    next_hs      = traverse_pkg::HS_GAP;
                end
            end
            traverse_pkg::HS_GAP: begin
                // interrupts held back until spacing elapsed
                // a tick in the start cycle itself would shorten the spacing
                if (lnk.ipo_tick && !start_q)
                    next_gap = gap + 1'b1;
                if (gap == traverse_pkg::GAP_LAST)
                    next_hs = traverse_pkg::HS_RUN;
            end
            traverse_pkg::HS_RUN: begin
                next_hold_q = HOLD;
                next_rej_q  = ABORT;
                if (!lnk.block_active && !start_q && !lnk.halted && lnk.in_position) begin
                    next_busy_q = 1'b0;
                    next_done_q = 1'b1;
                    next_hs     = traverse_pkg::HS_WAIT;
                end else if (!lnk.block_active && !lnk.halted) begin
                    next_busy_q = 1'b0;
                    next_hs     = traverse_pkg::HS_WAIT;
                end
            end
            default: next_hs = traverse_pkg::HS_WAIT;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            hs      <= traverse_pkg::HS_WAIT;
            gap     <= '0;
            start_q <= 1'b0;
            hold_q  <= 1'b0;
            rej_q   <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            hs      <= next_hs;
            gap     <= next_gap;
            start_q <= next_start_q;
            hold_q  <= next_hold_q;
            rej_q   <= next_rej_q;
            busy_q  <= next_busy_q;
            done_q  <= next_done_q;
        end
    end

    // one-cycle start pulse, levels for interrupts
    assign lnk.start_task     = start_q;
    assign lnk.stop_hold      = hold_q;
    assign lnk.reject_task    = rej_q;
    assign lnk.jog_req        = JOG && !start_q;
    assign lnk.ref_req        = HOME && !start_q;
    assign lnk.is_dwell       = GO_DWELL;
    assign lnk.dwell_time     = DWELL_TIME;
    assign lnk.target_pos     = TARGET;
    assign lnk.use_bus_target = BUS_TARGET_SEL;
    assign lnk.bus_target     = TARGET;
    assign BUSY               = busy_q;
    assign DONE               = done_q;
endmodule
`default_nettype wire

//--- dv/traverse_properties.sv
`timescale 1ns/1ps
`default_nettype none
module traverse_properties (
    // clock and reset
    input wire logic                           CLK_SYS,
    input wire logic                           RSTN,
    // link signals
    input wire logic                           start_task,
    input wire logic                           stop_hold,
    input wire logic                           reject_task,
    input wire logic                           jog_req,
    input wire logic                           ref_req,
    input wire logic                           enables_ok,
    input wire logic                           ctrl_enabled,
    input wire logic                           followup_active_status_bit,
    input wire logic                           block_active,
    input wire logic                           in_position,
    input wire logic                           halted,
    input wire logic                           ipo_tick,
    input wire logic [traverse_pkg::POS_W-1:0] actual_pos
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    // ticks seen since the last start, saturating at three
    logic [1:0] gap;
    logic [1:0] next_gap;
    always_comb begin
        next_gap = gap;
        if (start_task)
            next_gap = 2'h0;
        else if (ipo_tick && gap != 2'h3)
            next_gap = gap + 2'h1;
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN)
            gap <= 2'h3;
        else
            gap <= next_gap;
    end

    chk_start_preconds: assert property (start_task |-> enables_ok && ctrl_enabled && !followup_active_status_bit)
        else $error("start issued without enables or during follow-up");
    chk_start_after_done: assert property (start_task |-> in_position && !block_active)
        else $error("start issued before previous block completed");
    chk_interrupt_gap: assert property (($rose(stop_hold) || $rose(reject_task)) |-> gap == 2'h3)
        else $error("interrupt raised too soon after start");
    chk_start_taken: assert property (start_task && !block_active && !followup_active_status_bit |=> block_active)
        else $error("valid start not taken");
    chk_stop_halts: assert property (stop_hold && block_active && !reject_task && !jog_req && !ref_req |=> halted)
        else $error("stop did not halt block");
    chk_halt_freeze: assert property (halted && $past(halted) |-> $stable(actual_pos))
        else $error("position moved while halted");
    chk_halt_resume: assert property (halted && !stop_hold && !reject_task && !jog_req && !ref_req
        |=> !halted && block_active)
        else $error("halted block not resumed");
    chk_jog_abandons: assert property (halted && jog_req && !reject_task |=> !block_active && followup_active_status_bit)
        else $error("jog did not abandon halted block");
    chk_reject_ends: assert property (reject_task && block_active |=> !block_active && !halted)
        else $error("reject did not end block");
    chk_no_restart: assert property (!block_active && !start_task |=> !block_active)
        else $error("block became active without start");
    chk_idle_in_pos: assert property ($fell(block_active) && !followup_active_status_bit |-> in_position)
        else $error("block ended away from position");
endmodule
`default_nettype wire

//--- dv/test_traversing_block_start_stop_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_traversing_block_start_stop_control;
    logic                           clk_sys, rstn, drv_enables, drv_ctrl_enabled;
    logic                           go, go_dwell, bus_target_sel, hold, abort, jog, home, busy, done;
    logic [traverse_pkg::DWELL_W-1:0] dwell_time;
    logic [traverse_pkg::POS_W-1:0]   target, spindle_setting, snap, tgt, held;
    logic [traverse_pkg::POS_W-1:0]   exp_q[$];
    int                             err_count, compares, n;

    traverse_if traverse_if_inst ();
    traverse_device traverse_device_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .DRV_ENABLES(drv_enables),
        .DRV_CTRL_ENABLED(drv_ctrl_enabled), .SPINDLE_TARGET_SETTING(spindle_setting), .lnk(traverse_if_inst));
    traverse_host traverse_host_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .GO(go), .GO_DWELL(go_dwell),
        .DWELL_TIME(dwell_time), .TARGET(target), .BUS_TARGET_SEL(bus_target_sel), .HOLD(hold), .ABORT(abort),
        .JOG(jog), .HOME(home), .BUSY(busy), .DONE(done), .lnk(traverse_if_inst));
    traverse_properties traverse_properties_inst (.CLK_SYS(clk_sys), .RSTN(rstn),
        .start_task(traverse_if_inst.start_task), .stop_hold(traverse_if_inst.stop_hold),
        .reject_task(traverse_if_inst.reject_task), .jog_req(traverse_if_inst.jog_req),
        .ref_req(traverse_if_inst.ref_req), .enables_ok(traverse_if_inst.enables_ok),
        .ctrl_enabled(traverse_if_inst.ctrl_enabled),
        .followup_active_status_bit(traverse_if_inst.followup_active_status_bit),
        .block_active(traverse_if_inst.block_active), .in_position(traverse_if_inst.in_position),
        .halted(traverse_if_inst.halted), .ipo_tick(traverse_if_inst.ipo_tick),
        .actual_pos(traverse_if_inst.actual_pos));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [traverse_pkg::POS_W-1:0] seen, input logic [traverse_pkg::POS_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic ticks(input int k);
        int i;
        repeat (k) begin
            i = 0;
            do begin
                @(posedge clk_sys);
                i++;
            end while (traverse_if_inst.ipo_tick !== 1'b1 && i < 500);
            if (i >= 500) begin
                err_count++;
                conclude();
            end
        end
    endtask

    task automatic start(input logic dw, input logic [traverse_pkg::POS_W-1:0] t, input logic sel);
        go <= !dw;
        go_dwell <= dw;
        target <= t;
        bus_target_sel <= sel;
        // block kind must still stand when the device takes the start a cycle later
        repeat (2) @(posedge clk_sys);
        go <= 1'b0;
        go_dwell <= 1'b0;
        @(posedge clk_sys);
    endtask

    // counts ticks until host and device are both idle
    task automatic finish_blk(output int nt);
        int i;
        nt = 0;
        for (i = 0; i < 20000 && (busy !== 1'b0 || traverse_if_inst.block_active !== 1'b0); i++) begin
            @(posedge clk_sys);
            if (traverse_if_inst.ipo_tick === 1'b1)
                nt++;
        end
        if (i >= 20000) begin
            err_count++;
            conclude();
        end
    endtask

    // an abort pulses done with nothing queued for it, so an empty queue is not an error
    always @(posedge clk_sys) begin
        if (done === 1'b1 && exp_q.size() > 0)
            check(traverse_if_inst.actual_pos, exp_q.pop_front());
    end

    initial begin
        rstn = 1'b0;
        drv_enables = 1'b1;
        drv_ctrl_enabled = 1'b1;
        {go, go_dwell, bus_target_sel, hold, abort, jog, home} = 7'h00;
        dwell_time = 16'h0000;
        target = 32'h0000_0000;
        err_count = 0;
        compares = 0;
        void'($urandom(63757));
        spindle_setting = $urandom;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        snap = 32'h0000_0000;
        for (int k = 0; k < 2; k++) begin
            tgt = snap + 32'h0000_0001 + ($urandom % 3);
            exp_q.push_back(tgt);
            start(1'b0, tgt, k[0]);
            finish_blk(n);
            snap = tgt;
        end
        tgt = snap + 32'h0000_0008;
        exp_q.push_back(tgt);
        start(1'b0, tgt, 1'b0);
        check(busy, 1'b1);
        ticks(4);
        hold <= 1'b1;
        ticks(2);
        check(traverse_if_inst.halted, 1'b1);
        held = traverse_if_inst.actual_pos;
        ticks(2);
        check(traverse_if_inst.actual_pos, held);
        hold <= 1'b0;
        finish_blk(n);
        snap = tgt;
        // unfrozen dwell would expire under the hold and leave nothing after release
        dwell_time <= 16'h0006;
        exp_q.push_back(snap);
        start(1'b1, snap, 1'b0);
        ticks(3);
        hold <= 1'b1;
        ticks(4);
        hold <= 1'b0;
        finish_blk(n);
        check(n >= 2, 1'b1);
        start(1'b0, snap + 32'h0000_0008, 1'b0);
        ticks(4);
        abort <= 1'b1;
        ticks(1);
        check(traverse_if_inst.block_active, 1'b0);
        check(busy, 1'b0);
        check(traverse_if_inst.in_position, 1'b1);
        abort <= 1'b0;
        held = traverse_if_inst.actual_pos;
        ticks(3);
        check(traverse_if_inst.block_active, 1'b0);
        check(traverse_if_inst.actual_pos, held);
        finish_blk(n);
        start(1'b0, held + 32'h0000_0008, 1'b0);
        ticks(4);
        hold <= 1'b1;
        ticks(1);
        jog <= 1'b1;
        ticks(1);
        check(traverse_if_inst.followup_active_status_bit, 1'b1);
        check(traverse_if_inst.block_active, 1'b0);
        jog <= 1'b0;
        hold <= 1'b0;
        ticks(2);
        check(traverse_if_inst.block_active, 1'b0);
        finish_blk(n);
        start(1'b0, traverse_if_inst.actual_pos + 32'h0000_0008, 1'b0);
        ticks(4);
        hold <= 1'b1;
        ticks(1);
        home <= 1'b1;
        ticks(1);
        check(traverse_if_inst.actual_pos, 32'h0000_0000);
        check(traverse_if_inst.block_active, 1'b0);
        home <= 1'b0;
        hold <= 1'b0;
        finish_blk(n);
        drv_enables <= 1'b0;
        ticks(1);
        start(1'b0, 32'h0000_0005, 1'b0);
        ticks(1);
        check(traverse_if_inst.block_active, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
